// *** hw/qad_frame_ctrl.sv ***
`timescale 1ns/1ps
`include "qad_consts.svh"

// Behaviour
// - First three serial clocks after frame start keep the input tracking.
// - Clocks four to sixteen hold the sample and run the conversion.
// - Frame starts on select falling and ends on select rising.
// - Serial output floats while select high, driven while select low.
// - Power down while select high and in gaps between conversions.
// - Result leaves MSB first over twelve clocks, first bit on clock five.
// - Each further conversion re-tracks after edge 16N, holds four falls later.
// - Clock ignored while idle; select falling counts as first falling edge.
// - With clock resting high, tracking starts at select falling; the first real falling edge keeps it.
// - First eight rising edges of each conversion shift in the control word.
// - No start-up delay; first conversion after power-up samples input one.
// - Only control bits five to three form the channel address.
// - Low two address bits pick inputs one to four; top bit ignored.
// - Results are twelve-bit straight binary, one step per supply/4096.
// - Conversions continue back to back while select stays low.

module qad_frame_ctrl #(
	parameter int RES_BITS = `QAD_RES_BITS,
	parameter int NUM_CHAN = 4
) (
	input  wire logic                clk_sys,         // System clock
	input  wire logic                rst_n,           // Reset, active low
	input  wire logic                sclk,            // Link serial clock
	input  wire logic                frame_sel_n,     // Frame select, low
	input  wire logic                ser_din,         // Serial control in
	output logic                     ser_dout,        // Serial result out
	output logic                     ser_dout_oe,     // Output enable
	input  wire logic [RES_BITS-1:0] analog_input_1,  // Input 1 level
	input  wire logic [RES_BITS-1:0] analog_input_2,  // Input 2 level
	input  wire logic [RES_BITS-1:0] analog_input_3,  // Input 3 level
	input  wire logic [RES_BITS-1:0] analog_input_4,  // Input 4 level
	output qad_pkg::qad_result_t     result,          // Last result
	output logic                     result_valid,    // New result pulse
	output logic                     power_down,      // Powered down
	output logic                     track_active,    // Tracking input
	output logic                     frame_active     // Frame under way
);

	// ------------------------------------------------------------------
	// Link domain: rising edges of the serial clock
	// ------------------------------------------------------------------

	logic [RES_BITS-1:0]  ain   [NUM_CHAN];
	logic [RES_BITS-1:0]  ain_s [NUM_CHAN];
	logic [3:0]           rise_cnt;
	logic [3:0]           next_rise_cnt;
	logic [7:0]           ctrl_shift;
	logic [7:0]           next_ctrl_shift;
	qad_pkg::qad_ctrl_t   ctrl_word;
	logic [7:0]           ctrl_last;
	logic [7:0]           next_ctrl_last;
	logic [1:0]           chan_next;
	logic [1:0]           next_chan_next;

	assign ain[0] = analog_input_1;
	assign ain[1] = analog_input_2;
	assign ain[2] = analog_input_3;
	assign ain[3] = analog_input_4;

	// Input levels settle into the link domain while tracking
	genvar g;
	generate
		for (g = 0; g < NUM_CHAN; g++) begin : g_ain
			qad_sync2 #(
				.WIDTH (RES_BITS)
			) u_ain_sync (
				.clk (sclk),
				.d   (ain[g]),
				.q   (ain_s[g])
			);
		end
	endgenerate

	assign ctrl_word = qad_pkg::qad_ctrl_t'({ctrl_shift[6:0], ser_din});

	always_comb begin
		next_rise_cnt   = rise_cnt + 4'h1;
		next_ctrl_shift = ctrl_shift;
		if (rise_cnt < `QAD_CTRL_BITS) begin
			next_ctrl_shift = ctrl_word;
		end
	end

	// frame select high clears the frame
	always_ff @(posedge sclk or posedge frame_sel_n) begin
		if (frame_sel_n) begin
			rise_cnt   <= 4'h0;
			ctrl_shift <= 8'h00;
		end else begin
			rise_cnt   <= next_rise_cnt;
			ctrl_shift <= next_ctrl_shift;
		end
	end

	always_comb begin
		next_chan_next = chan_next;
		next_ctrl_last = ctrl_last;
		if (rise_cnt == `QAD_CTRL_LAST) begin
			next_chan_next = {ctrl_word.chan_addr_bit1,
				ctrl_word.chan_addr_bit0};
			next_ctrl_last = ctrl_word;
		end
	end

	// Channel choice outlives the frame
	always_ff @(posedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			chan_next <= `QAD_CHAN_RESET;
			ctrl_last <= 8'h00;
		end else begin
			chan_next <= next_chan_next;
			ctrl_last <= next_ctrl_last;
		end
	end

	// ------------------------------------------------------------------
	// Link domain: falling edges of the serial clock
	// ------------------------------------------------------------------

	logic                 in_track;
	logic                 next_in_track;
	logic                 gap;
	logic                 next_gap;
	logic [1:0]           conv_chan;
	logic [1:0]           next_conv_chan;
	logic                 sar_load;
	logic                 sar_step;
	logic [RES_BITS-1:0]  sar_code;
	logic                 res_tog;
	logic                 next_res_tog;
	logic [1:0]           res_chan;
	logic [1:0]           next_res_chan;
	logic [7:0]           res_ctrl;
	logic [7:0]           next_res_ctrl;

	always_comb begin
		// back to tracking after edge 16N
		next_in_track  = rise_cnt < `QAD_HOLD_START;
		next_gap       = rise_cnt == `QAD_LAST_FALL;
		sar_load       = rise_cnt == `QAD_HOLD_START;
		sar_step       = rise_cnt >= `QAD_FIRST_RESULT;
		next_conv_chan = sar_load ? chan_next : conv_chan;
	end

	// idle state is tracking, so select falling acts as a fall
	// with clock high, the first real fall lands in the same state
	always_ff @(negedge sclk or posedge frame_sel_n) begin
		if (frame_sel_n) begin
			in_track  <= 1'b1;
			gap       <= 1'b0;
			conv_chan <= `QAD_CHAN_RESET;
		end else begin
			in_track  <= next_in_track;
			gap       <= next_gap;
			conv_chan <= next_conv_chan;
		end
	end

	qad_sar #(
		.WIDTH (RES_BITS)
	) u_sar (
		.clk       (sclk),
		.frame_rst (frame_sel_n),
		.rst_n     (rst_n),
		.load      (sar_load),
		.step      (sar_step),
		.sample    (ain_s[conv_chan_src(chan_next)]),
		.bit_out   (ser_dout),
		.code      (sar_code)
	);

	function automatic logic [1:0] conv_chan_src(input logic [1:0] c);
		conv_chan_src = c;
	endfunction

	// select acts as the output enable
	assign ser_dout_oe = ~frame_sel_n;

	always_comb begin
		next_res_tog  = res_tog;
		next_res_chan = res_chan;
		next_res_ctrl = res_ctrl;
		if (rise_cnt == `QAD_LAST_FALL) begin
			next_res_tog  = ~res_tog;
			next_res_chan = conv_chan;
			next_res_ctrl = ctrl_last;
		end
	end

	// Result word stands a whole conversion for the crossing
	always_ff @(negedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			res_tog  <= 1'b0;
			res_chan <= `QAD_CHAN_RESET;
			res_ctrl <= 8'h00;
		end else begin
			res_tog  <= next_res_tog;
			res_chan <= next_res_chan;
			res_ctrl <= next_res_ctrl;
		end
	end

	// ------------------------------------------------------------------
	// System domain
	// ------------------------------------------------------------------

	qad_pkg::qad_link_t   link_raw;
	qad_pkg::qad_link_t   link_s;
	qad_pkg::qad_phase_t  phase;
	qad_pkg::qad_phase_t  next_phase;
	logic                 seen_tog;
	logic                 next_seen_tog;
	qad_pkg::qad_result_t next_result;
	logic                 next_result_valid;

	assign link_raw.frame_idle = frame_sel_n;
	assign link_raw.track      = in_track;
	assign link_raw.gap        = gap;
	assign link_raw.res_tog    = res_tog;

	qad_sync2 #(
		.WIDTH ($bits(qad_pkg::qad_link_t))
	) u_link_sync (
		.clk (clk_sys),
		.d   (link_raw),
		.q   (link_s)
	);

	always_comb begin
		next_seen_tog     = link_s.res_tog;
		next_result       = result;
		next_result_valid = 1'b0;
		if (link_s.res_tog != seen_tog) begin
			next_result.chan  = res_chan;
			next_result.ctrl  = res_ctrl;
			next_result.code  = sar_code;
			next_result_valid = 1'b1;
		end
		// powered down when idle or between conversions
		if (link_s.frame_idle || link_s.gap) begin
			next_phase = qad_pkg::qad_ph_down;
		end else if (link_s.track) begin
			next_phase = qad_pkg::qad_ph_track;
		end else begin
			next_phase = qad_pkg::qad_ph_hold;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			seen_tog     <= 1'b0;
			result       <= '0;
			result_valid <= 1'b0;
			phase        <= qad_pkg::qad_ph_down;
			power_down   <= 1'b1;
			track_active <= 1'b0;
			frame_active <= 1'b0;
		end else begin
			seen_tog     <= next_seen_tog;
			result       <= next_result;
			result_valid <= next_result_valid;
			phase        <= next_phase;
			case (next_phase)
				qad_pkg::qad_ph_down: begin
					power_down   <= 1'b1;
					track_active <= 1'b0;
				end
				qad_pkg::qad_ph_track: begin
					power_down   <= 1'b0;
					track_active <= 1'b1;
				end
				default: begin
					power_down   <= 1'b0;
					track_active <= 1'b0;
				end
			endcase
			frame_active <= ~link_s.frame_idle;
		end
	end

endmodule // qad_frame_ctrl

// *** hw/qad_sar.sv ***
`timescale 1ns/1ps
`include "qad_consts.svh"

module qad_sar #(
	parameter int WIDTH = `QAD_RES_BITS
) (
	input  wire logic             clk,        // Serial clock, falling edges
	input  wire logic             frame_rst,  // High outside a frame
	input  wire logic             rst_n,      // Power-up reset
	input  wire logic             load,       // Take sample, start hold
	input  wire logic             step,       // Decide one bit
	input  wire logic [WIDTH-1:0] sample,     // Tracked input level
	output logic                  bit_out,    // Bit on the serial output
	output logic      [WIDTH-1:0] code        // Last finished result
);

	logic [WIDTH-1:0] held;
	logic [WIDTH-1:0] approx;
	logic [WIDTH-1:0] trial;
	logic [WIDTH-1:0] cand;
	logic             decide;
	logic [WIDTH-1:0] next_held;
	logic [WIDTH-1:0] next_approx;
	logic [WIDTH-1:0] next_trial;
	logic             next_bit_out;
	logic [WIDTH-1:0] next_code;

	always_comb begin
		cand         = approx | trial;
		decide       = held >= cand;
		next_held    = held;
		next_approx  = approx;
		next_trial   = trial;
		next_bit_out = 1'b0;
		next_code    = code;
		if (load) begin
			next_held   = sample;
			next_approx = '0;
			next_trial  = WIDTH'(`QAD_SAR_MSB);
		end else if (step) begin
			// Result is straight binary, MSB decided first
			next_approx  = decide ? cand : approx;
			next_trial   = trial >> 1;
			next_bit_out = decide;
			if (trial == WIDTH'(`QAD_SAR_LSB)) begin
				next_code = decide ? cand : approx;
			end
		end
	end

	always_ff @(negedge clk or posedge frame_rst) begin
		if (frame_rst) begin
			held    <= '0;
			approx  <= '0;
			trial   <= '0;
			bit_out <= 1'b0;
		end else begin
			held    <= next_held;
			approx  <= next_approx;
			trial   <= next_trial;
			bit_out <= next_bit_out;
		end
	end

	always_ff @(negedge clk or negedge rst_n) begin
		if (!rst_n) begin
			code <= WIDTH'(`QAD_RES_RESET);
		end else begin
			code <= next_code;
		end
	end

endmodule // qad_sar

// *** hw/qad_sync2.sv ***
`timescale 1ns/1ps

module qad_sync2 #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,  // Destination clock
	input  wire logic [WIDTH-1:0] d,    // Asynchronous input
	output logic      [WIDTH-1:0] q     // Synchronised output
);

	logic [WIDTH-1:0] meta;

	always_ff @(posedge clk) begin
		meta <= d;
		q    <= meta;
	end

endmodule // qad_sync2

// *** shared/qad_consts.svh ***
`ifndef QAD_CONSTS_SVH
`define QAD_CONSTS_SVH

// Serial clocks per conversion
`define QAD_CONV_CLOCKS 16
// Rising-edge count at which hold begins (fourth falling edge)
`define QAD_HOLD_START 4'h3
// Rising-edge count at which the first result bit is driven
`define QAD_FIRST_RESULT 4'h4
// Rising-edge count at the sixteenth falling edge
`define QAD_LAST_FALL 4'hF
// Control bits captured per conversion
`define QAD_CTRL_BITS 4'h8
`define QAD_CTRL_LAST 4'h7
// Channel address field in the control word
`define QAD_CHAN_HI 4
`define QAD_CHAN_LO 3
`define QAD_CHAN_RESET 2'h0
// Result format
`define QAD_RES_BITS 12
`define QAD_SAR_MSB 12'h800
`define QAD_SAR_LSB 12'h001
`define QAD_RES_RESET 12'h000

`endif

// *** shared/qad_pkg.sv ***
package qad_pkg;

	// Control word as shifted in on the data input
	typedef struct packed {
		logic [1:0] ignored_bit_hi;
		logic       chan_addr_bit2;
		logic       chan_addr_bit1;
		logic       chan_addr_bit0;
		logic [2:0] ignored_bit_lo;
	} qad_ctrl_t;

	// One finished conversion
	typedef struct packed {
		logic [1:0]  chan;
		logic [7:0]  ctrl;
		logic [11:0] code;
	} qad_result_t;

	// Levels handed from the link domain to the system domain
	typedef struct packed {
		logic frame_idle;
		logic track;
		logic gap;
		logic res_tog;
	} qad_link_t;

	typedef enum logic [1:0] {
		qad_ph_down,
		qad_ph_track,
		qad_ph_hold
	} qad_phase_t;

endpackage

// *** verif/qad_frame_ctrl_assertions.sv ***
`timescale 1ns/1ps

module qad_frame_ctrl_checker (
	input wire logic                 clk_sys,      // System clock
	input wire logic                 rst_n,        // Reset
	input wire logic                 sclk,         // Serial clock
	input wire logic                 frame_sel_n,  // Frame select
	input wire logic                 ser_dout,     // Result bit
	input wire logic                 ser_dout_oe,  // Output enable
	input wire qad_pkg::qad_result_t result,       // Last result
	input wire logic                 result_valid, // New result
	input wire logic                 power_down,   // Powered down
	input wire logic                 track_active, // Tracking
	input wire logic                 frame_active  // In frame
);
	logic [3:0] rises;
	logic [3:0] next_rises;

	// Rising edges seen in this conversion
	always_comb begin
		next_rises = rises + 4'h1;
	end

	always_ff @(posedge sclk or posedge frame_sel_n) begin
		if (frame_sel_n) begin
			rises <= 4'h0;
		end else begin
			rises <= next_rises;
		end
	end

	a_oe_follows_sel: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		ser_dout_oe == !frame_sel_n) else $error("dout enable wrong");
	a_dout_zero_early: assert property (
		@(posedge sclk) disable iff (frame_sel_n || !rst_n)
		rises < 4'h4 |-> !ser_dout) else $error("dout not zero early");
	a_idle_power_down: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		frame_sel_n [*4] |-> power_down && !frame_active && !track_active)
		else $error("idle not powered down");
	a_frame_goes_active: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		$fell(frame_sel_n) |-> ##[1:4] frame_active)
		else $error("frame not active");
	a_track_at_start: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		$fell(frame_sel_n) |-> ##[1:4] track_active)
		else $error("no tracking at frame start");
	a_track_awake: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		track_active |-> !power_down) else $error("tracking while down");
	a_valid_single: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		result_valid |=> !result_valid) else $error("valid too long");
	a_result_on_valid: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		$changed(result) |-> result_valid) else $error("result moved alone");
endmodule // qad_frame_ctrl_checker

bind qad_frame_ctrl qad_frame_ctrl_checker u_chk (
	.clk_sys(clk_sys), .rst_n(rst_n), .sclk(sclk),
	.frame_sel_n(frame_sel_n), .ser_dout(ser_dout),
	.ser_dout_oe(ser_dout_oe), .result(result),
	.result_valid(result_valid), .power_down(power_down),
	.track_active(track_active), .frame_active(frame_active)
);

// *** verif/qad_host_model.sv ***
`timescale 1ns/1ps

module qad_host_model (
	output logic      sclk,        // Serial clock
	output logic      frame_sel_n, // Frame select
	output logic      ser_din,     // Control bits
	input  wire logic dout_pin     // Result line
);
	logic [11:0] rx [4];

	// Deselect edge after time zero so the frame state clears for sure
	initial begin
		sclk = 1'b0;
		frame_sel_n = 1'b0;
		ser_din = 1'b0;
		#1 frame_sel_n = 1'b1;
	end

	task automatic frame(input int nclk, input bit hi, input realtime hp,
		input realtime gap, input logic [31:0] w);
		int m;
		int c;
		sclk = hi;
		#(hp);
		frame_sel_n = 1'b0;
		#(2 * hp);
		for (int k = 0; k < nclk; k++) begin
			m = k % 16;
			c = (k / 16) % 4;
			sclk = 1'b0;
			ser_din = (m < 8) ? w[8 * c + 7 - m] : ~ser_din;
			#(hp);
			sclk = 1'b1;
			if (m >= 4) rx[c][15 - m] = dout_pin;
			#(hp);
			if (m == 15 && k + 1 < nclk) #(gap);
		end
		sclk = hi;
		#(hp);
		frame_sel_n = 1'b1;
		ser_din = ~ser_din;
	endtask
endmodule // qad_host_model

// *** verif/quad_adc_serial_frame_control_tb.sv ***
`timescale 1ns/1ps

module quad_adc_serial_frame_control_tb;
	logic                 clk_sys;
	logic                 rst_n;
	wire                  sclk;
	wire                  frame_sel_n;
	wire                  ser_din;
	wire                  dout_pin;
	logic                 ser_dout;
	logic                 ser_dout_oe;
	logic [11:0]          lvl [4];
	logic [1:0]           exp_ch;
	logic                 result_valid;
	logic                 power_down;
	logic                 track_active;
	logic                 frame_active;
	int                   n_mismatch;
	int                   compares;
	int                   cycles;
	qad_pkg::qad_result_t result;
	qad_pkg::qad_result_t resq [$];

	assign dout_pin = ser_dout_oe ? ser_dout : 1'bz;

	qad_frame_ctrl dut (
		.clk_sys(clk_sys), .rst_n(rst_n), .sclk(sclk),
		.frame_sel_n(frame_sel_n), .ser_din(ser_din),
		.ser_dout(ser_dout), .ser_dout_oe(ser_dout_oe),
		.analog_input_1(lvl[0]), .analog_input_2(lvl[1]),
		.analog_input_3(lvl[2]), .analog_input_4(lvl[3]),
		.result(result), .result_valid(result_valid),
		.power_down(power_down), .track_active(track_active),
		.frame_active(frame_active)
	);

	qad_host_model host (
		.sclk(sclk), .frame_sel_n(frame_sel_n), .ser_din(ser_din),
		.dout_pin(dout_pin)
	);

	always #20 clk_sys = ~clk_sys;

	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (result_valid === 1'b1) resq.push_back(result);
		if (cycles == 20000) begin
			n_mismatch++;
			stop_test();
		end
	end

	task automatic stop_test;
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic cmp(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic run(input string name, input int nclk, input bit hi,
		input realtime hp, input realtime gap, input logic [31:0] w);
		int n;
		n = nclk / 16;
		resq.delete();
		host.frame(nclk, hi, hp, gap, w);
		repeat (10) @(posedge clk_sys);
		#1;
		cmp("idle dout_oe", 0, ser_dout_oe);
		cmp("idle power_down", 1, power_down);
		cmp("result count", n, resq.size());
		for (int c = 0; c < n; c++) begin
			cmp("dout code", lvl[exp_ch], host.rx[c]);
			cmp("result code", lvl[exp_ch], resq[c].code);
			cmp("result chan", exp_ch, resq[c].chan);
			cmp("result ctrl", w[8 * c +: 8], resq[c].ctrl);
			exp_ch = w[8 * c + 3 +: 2];
		end
		$display("done %s", name);
	endtask

	initial begin
		clk_sys = 1'b0;
		rst_n = 1'b1;
		cycles = 0;
		n_mismatch = 0;
		compares = 0;
		exp_ch = 2'h0;
		lvl = '{12'h5A3, 12'hFFF, 12'h000, 12'h801};
		// Reset edge after time zero reaches the async clears
		#1 rst_n = 1'b0;
		repeat (20) @(posedge clk_sys);
		#1 rst_n = 1'b1;
		repeat (3) @(posedge clk_sys);
		#1;
		run("back_to_back", 64, 1'b0, 7.5, 0, 32'h0038D7EF);
		fork
			run("resting_high_gap", 32, 1'b1, 20, 400, 32'h0000C818);
			begin
				#160;
				cmp("start track_active", 1, track_active);
				#140;
				cmp("busy power_down", 0, power_down);
				cmp("busy track_active", 0, track_active);
				#600;
				cmp("gap power_down", 1, power_down);
				cmp("gap frame_active", 1, frame_active);
				cmp("gap track_active", 0, track_active);
			end
		join
		run("partial", 7, 1'b0, 7.5, 0, 32'h000000FF);
		run("after_partial", 16, 1'b0, 15, 0, 32'h00000010);
		stop_test();
	end
endmodule // quad_adc_serial_frame_control_tb
